// [hw/tpm_edge_mon.sv]
// Purpose: Synchronise one port input and report its stable level and edges.
// Assumes: Input comes from a pin outside the clock domain.
// Notes: A change counts once the second and third stages agree.
`timescale 1ns/10ps
module tpm_edge_mon import tpm_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pin_i,
   input wire logic cmp_on_i,
   output logic level_o,
   output logic event_o
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic evt;
   } tpm_mon_st_t;

   tpm_mon_st_t st_ff;
   tpm_mon_st_t nxt_st;

   // Only s2 reads s1; the level moves when the two later stages agree.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.s1 = pin_i;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      nxt_st.evt = 1'b0;
      if (st_ff.s2 == st_ff.s3 && st_ff.s3 != st_ff.lvl) begin
         nxt_st.lvl = st_ff.s3;
         nxt_st.evt = cmp_on_i;
      end
   end

   // Reset to a low level; a high pin yields one event after reset if enabled.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign level_o = st_ff.lvl;
   assign event_o = st_ff.evt;
endmodule

// [hw/tpm_pkg.sv]
// Purpose: Shared constants and types for the port data mux control.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes: Pin indices address the six-bit port pin vectors of the top module.
// Function
// - Swap top and bottom pair assignments when cable orientation is reversed.
// - Sideband crossbar swaps its two pins when orientation is reversed.
// - Root, endpoint and aux pairs selectable to top or bottom; aux also sideband.
// - Serial channel zero on top pins, one on bottom, two on sideband.
// - Firmware sets each external serial pin as input or output, and the routing.
// - After reset, until configured, transmit pin mirrors the buffered receive pin.
// - Serial path is buffered and its drivers can be released to high impedance.
// - Each port input has an enableable edge comparator that signals the core.
// - Software can disconnect comparators on pins carrying analog voltages.
// - Each of the six port pins has its own pull-up and pull-down selection.
// - Clamp is connected to a pin only while a second-stage path is closed.
// - Low-speed endpoint at 1.5 Mbps is routed and paced for EP0 enumeration.
// - Endpoint pull-up is disconnected while the endpoint transmits.
// - In receive, endpoint pull-up goes to the orientation-selected D- pin.
// - During contact detect, current on chosen D+ and pull-down on chosen D-.
// - Twelve firmware switches apply source, sink or read path to four D pins.
// - Detect voltage source and current sink only during charger detection.
package tpm_pkg;
   // Port pin indices.
   localparam int PIN_TOP_DP = 0;
   localparam int PIN_TOP_DM = 1;
   localparam int PIN_BOT_DP = 2;
   localparam int PIN_BOT_DM = 3;
   localparam int PIN_SB_ONE = 4;
   localparam int PIN_SB_TWO = 5;
   localparam int PORT_PINS = 6;
   localparam int DATA_PINS = 4;
   // Charger switch field positions inside the twelve-bit switch word.
   localparam int CHG_VSRC_LSB = 0;
   localparam int CHG_SINK_LSB = 4;
   localparam int CHG_ADC_LSB = 8;
   localparam int CHG_SWITCHES = 12;
   // Low-speed bit pacing.
   localparam longint CLK_HZ = 100_000_000;
   localparam longint LS_RATE_HZ = 1_500_000;
   localparam int LS_TICK_CYC = int'(CLK_HZ / LS_RATE_HZ);
   // Serial idle level.
   localparam logic SER_IDLE = 1'b1;

   // Source that a pair or the sideband pins may carry.
   typedef enum logic [2:0] {
      SRC_NONE = 3'b000,
      SRC_ROOT = 3'b001,
      SRC_LSEP = 3'b010,
      SRC_AUX  = 3'b011,
      SRC_UART = 3'b100
   } tpm_src_t;
endpackage

// [hw/tpm_port_mux.sv]
// Purpose: Control of the connector-side port data multiplexer.
// Assumes: Orientation and phase inputs come from logic on the same clock.
// Notes: Analog paths leave as switch selections; only the serial path is digital.
`timescale 1ns/10ps
module tpm_port_mux import tpm_pkg::*; #(
   parameter int TICK_CYC = LS_TICK_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic orient_flip_i,
   input tpm_src_t top_src_i,
   input tpm_src_t bottom_src_i,
   input tpm_src_t sbu_src_i,
   output tpm_src_t top_pair_src_o,
   output tpm_src_t bottom_pair_src_o,
   output tpm_src_t sbu_src_o,
   output logic sbu_swap_o,
   output logic select_conflict_o,
   input wire logic [PORT_PINS-1:0] port_pin_i,
   output logic [PORT_PINS-1:0] port_pin_o,
   output logic [PORT_PINS-1:0] port_pin_oe_o,
   input wire logic xbar_load_i,
   input wire logic xbar_rx_out_i,
   input wire logic xbar_tx_out_i,
   input wire logic [1:0] xbar_chan_i,
   input wire logic serial_hiz_i,
   output logic xbar_custom_o,
   input wire logic chain_rx_i,
   output logic chain_rx_o,
   output logic chain_rx_oe_o,
   input wire logic chain_tx_i,
   output logic chain_tx_o,
   output logic chain_tx_oe_o,
   input wire logic [PORT_PINS-1:0] cmp_en_i,
   input wire logic [PORT_PINS-1:0] analog_pin_i,
   output logic [PORT_PINS-1:0] port_event_o,
   input wire logic [PORT_PINS-1:0] pull_up_i,
   input wire logic [PORT_PINS-1:0] pull_dn_i,
   output logic [PORT_PINS-1:0] pull_up_o,
   output logic [PORT_PINS-1:0] pull_dn_o,
   output logic [PORT_PINS-1:0] clamp_en_o,
   input wire logic ep_tx_mode_i,
   output logic lowspeed_bit_tick_o,
   output logic [1:0] lowspeed_pullup_o,
   input wire logic contact_detect_i,
   output logic [1:0] contact_detect_current_o,
   output logic [1:0] contact_detect_pulldown_o,
   input wire logic charger_detect_i,
   input wire logic [CHG_SWITCHES-1:0] charger_sw_i,
   output logic [DATA_PINS-1:0] detect_voltage_source_o,
   output logic [DATA_PINS-1:0] detect_current_sink_o,
   output logic [DATA_PINS-1:0] adc_read_path_o
);
   typedef struct packed {
      logic custom;
      logic rx_out;
      logic tx_out;
      logic [1:0] chan;
      tpm_src_t top_src;
      tpm_src_t bot_src;
      tpm_src_t sbu_src;
      logic sbu_swap;
      logic conflict;
      logic [PORT_PINS-1:0] pin_o;
      logic [PORT_PINS-1:0] pin_oe;
      logic rx_o;
      logic rx_oe;
      logic tx_o;
      logic tx_oe;
      logic [PORT_PINS-1:0] pu;
      logic [PORT_PINS-1:0] pd;
      logic [PORT_PINS-1:0] clamp;
      logic [1:0] ls_pu;
      logic [1:0] dcd_cur;
      logic [1:0] dcd_pd;
      logic [DATA_PINS-1:0] vsrc;
      logic [DATA_PINS-1:0] sink;
      logic [DATA_PINS-1:0] adc;
   } tpm_top_st_t;

   tpm_top_st_t st_ff;
   tpm_top_st_t nxt_st;

   logic [PORT_PINS-1:0] pin_lvl;
   logic [PORT_PINS-1:0] cmp_on;
   logic rx_lvl;
   logic tx_lvl;
   logic ep_routed;

   // Comparators run only when enabled and the pin is not carrying an analog level.
   assign cmp_on = cmp_en_i & ~analog_pin_i;

   // One synchroniser and edge detector per port pin.
   for (genvar g = 0; g < PORT_PINS; g++) begin : g_mon
      tpm_edge_mon u_mon (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .pin_i(port_pin_i[g]),
         .cmp_on_i(cmp_on[g]),
         .level_o(pin_lvl[g]),
         .event_o(port_event_o[g])
      );
   end

   // The chain pins are synchronised the same way; their edges are not reported.
   tpm_edge_mon u_rx_mon (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(chain_rx_i),
      .cmp_on_i(1'b0),
      .level_o(rx_lvl),
      .event_o()
   );

   tpm_edge_mon u_tx_mon (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(chain_tx_i),
      .cmp_on_i(1'b0),
      .level_o(tx_lvl),
      .event_o()
   );

   // Bit pacing for the endpoint engine, running only while it owns a pair.
   assign ep_routed = (st_ff.top_src == SRC_LSEP) || (st_ff.bot_src == SRC_LSEP);

   tpm_tick_div #(
      .DIV(TICK_CYC)
   ) u_ls_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(ep_routed),
      .tick_o(lowspeed_bit_tick_o)
   );

   // Only root, endpoint, aux and serial are meaningful on a pair.
   function automatic tpm_src_t pair_legal(input tpm_src_t s);
      pair_legal = SRC_NONE;
      if (s == SRC_ROOT || s == SRC_LSEP || s == SRC_AUX || s == SRC_UART) begin
         pair_legal = s;
      end
   endfunction

   // Routing, crossbar and termination control.
   always_comb begin
      tpm_src_t top_ok;
      tpm_src_t bot_ok;
      tpm_src_t sbu_ok;
      logic conf;
      logic [2:0] ch_tx;
      logic [2:0] ch_rx;
      logic xin;
      logic xout;
      logic sb_tx_pin;
      nxt_st = st_ff;
      top_ok = pair_legal(top_src_i);
      bot_ok = pair_legal(bottom_src_i);
      sbu_ok = SRC_NONE;
      conf = 1'b0;
      ch_tx = {3{SER_IDLE}};
      ch_rx = {3{SER_IDLE}};
      xin = SER_IDLE;
      xout = SER_IDLE;
      sb_tx_pin = 1'b0;

      // A source other than serial may occupy one pair only; the top request wins a clash.
      if (bot_ok == top_ok && bot_ok != SRC_NONE && bot_ok != SRC_UART) begin
         bot_ok = SRC_NONE;
         conf = 1'b1;
      end
      if (sbu_src_i == SRC_AUX || sbu_src_i == SRC_UART) begin
         sbu_ok = sbu_src_i;
      end
      if (sbu_ok == SRC_AUX && (top_ok == SRC_AUX || bot_ok == SRC_AUX)) begin
         sbu_ok = SRC_NONE;
         conf = 1'b1;
      end
      if (sbu_src_i != SRC_NONE && sbu_ok == SRC_NONE && sbu_src_i != SRC_AUX) begin
         conf = 1'b1;
      end
      nxt_st.conflict = conf;

      // Selections are given for the upright cable; a flipped cable swaps them.
      nxt_st.top_src = orient_flip_i ? bot_ok : top_ok;
      nxt_st.bot_src = orient_flip_i ? top_ok : bot_ok;
      nxt_st.sbu_src = sbu_ok;
      nxt_st.sbu_swap = orient_flip_i;

      // Firmware loads the crossbar on each load strobe; only reset returns it to the bypass.
      if (xbar_load_i) begin
         nxt_st.custom = 1'b1;
         nxt_st.rx_out = xbar_rx_out_i;
         nxt_st.tx_out = xbar_tx_out_i;
         nxt_st.chan = xbar_chan_i;
      end

      // Channel receive data from the port; channel two's pin follows the sideband swap.
      ch_rx[0] = pin_lvl[PIN_TOP_DM];
      ch_rx[1] = pin_lvl[PIN_BOT_DM];
      ch_rx[2] = st_ff.sbu_swap ? pin_lvl[PIN_SB_ONE] : pin_lvl[PIN_SB_TWO];

      // The first pin configured as input feeds the chosen channel.
      if (!st_ff.rx_out) begin
         xin = rx_lvl;
      end else if (!st_ff.tx_out) begin
         xin = tx_lvl;
      end
      if (st_ff.chan < 2'd3) begin
         ch_tx[st_ff.chan] = xin;
         xout = ch_rx[st_ff.chan];
      end

      // External serial pins: bypass until configured, then per-pin direction.
      if (!st_ff.custom) begin
         nxt_st.rx_o = SER_IDLE;
         nxt_st.rx_oe = 1'b0;
         nxt_st.tx_o = rx_lvl;
         nxt_st.tx_oe = ~serial_hiz_i;
      end else begin
         nxt_st.rx_o = xout;
         nxt_st.rx_oe = st_ff.rx_out & ~serial_hiz_i;
         nxt_st.tx_o = xout;
         nxt_st.tx_oe = st_ff.tx_out & ~serial_hiz_i;
      end

      // Port pins are driven digitally only by the serial channels.
      nxt_st.pin_o = {PORT_PINS{SER_IDLE}};
      nxt_st.pin_oe = '0;
      if (st_ff.top_src == SRC_UART) begin
         nxt_st.pin_o[PIN_TOP_DP] = ch_tx[0];
         nxt_st.pin_oe[PIN_TOP_DP] = ~serial_hiz_i;
      end
      if (st_ff.bot_src == SRC_UART) begin
         nxt_st.pin_o[PIN_BOT_DP] = ch_tx[1];
         nxt_st.pin_oe[PIN_BOT_DP] = ~serial_hiz_i;
      end
      if (st_ff.sbu_src == SRC_UART) begin
         sb_tx_pin = st_ff.sbu_swap;
         if (sb_tx_pin) begin
            nxt_st.pin_o[PIN_SB_TWO] = ch_tx[2];
            nxt_st.pin_oe[PIN_SB_TWO] = ~serial_hiz_i;
         end else begin
            nxt_st.pin_o[PIN_SB_ONE] = ch_tx[2];
            nxt_st.pin_oe[PIN_SB_ONE] = ~serial_hiz_i;
         end
      end

      // Requesting both pulls on a pin would fight, so neither is applied then.
      nxt_st.pu = pull_up_i & ~pull_dn_i;
      nxt_st.pd = pull_dn_i & ~pull_up_i;

      // A clamp follows the closed second-stage path onto its pin.
      nxt_st.clamp = '0;
      nxt_st.clamp[PIN_TOP_DP] = (nxt_st.top_src != SRC_NONE);
      nxt_st.clamp[PIN_TOP_DM] = (nxt_st.top_src != SRC_NONE);
      nxt_st.clamp[PIN_BOT_DP] = (nxt_st.bot_src != SRC_NONE);
      nxt_st.clamp[PIN_BOT_DM] = (nxt_st.bot_src != SRC_NONE);
      nxt_st.clamp[PIN_SB_ONE] = (nxt_st.sbu_src != SRC_NONE);
      nxt_st.clamp[PIN_SB_TWO] = (nxt_st.sbu_src != SRC_NONE);

      // Endpoint pull-up: receive only, on the D- of the orientation pair.
      nxt_st.ls_pu = 2'b00;
      if (ep_routed && !ep_tx_mode_i) begin
         nxt_st.ls_pu = orient_flip_i ? 2'b10 : 2'b01;
      end

      // Contact detect elements live only for that phase.
      nxt_st.dcd_cur = 2'b00;
      nxt_st.dcd_pd = 2'b00;
      if (contact_detect_i) begin
         nxt_st.dcd_cur = orient_flip_i ? 2'b10 : 2'b01;
         nxt_st.dcd_pd = orient_flip_i ? 2'b10 : 2'b01;
      end

      // Twelve switches; source and sink are gated by the detection phase.
      nxt_st.vsrc = charger_detect_i ? charger_sw_i[CHG_VSRC_LSB +: DATA_PINS] : '0;
      nxt_st.sink = charger_detect_i ? charger_sw_i[CHG_SINK_LSB +: DATA_PINS] : '0;
      nxt_st.adc = charger_sw_i[CHG_ADC_LSB +: DATA_PINS];
   end

   // All control state resets to open switches and the serial bypass.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign top_pair_src_o = st_ff.top_src;
   assign bottom_pair_src_o = st_ff.bot_src;
   assign sbu_src_o = st_ff.sbu_src;
   assign sbu_swap_o = st_ff.sbu_swap;
   assign select_conflict_o = st_ff.conflict;
   assign port_pin_o = st_ff.pin_o;
   assign port_pin_oe_o = st_ff.pin_oe;
   assign xbar_custom_o = st_ff.custom;
   assign chain_rx_o = st_ff.rx_o;
   assign chain_rx_oe_o = st_ff.rx_oe;
   assign chain_tx_o = st_ff.tx_o;
   assign chain_tx_oe_o = st_ff.tx_oe;
   assign pull_up_o = st_ff.pu;
   assign pull_dn_o = st_ff.pd;
   assign clamp_en_o = st_ff.clamp;
   assign lowspeed_pullup_o = st_ff.ls_pu;
   assign contact_detect_current_o = st_ff.dcd_cur;
   assign contact_detect_pulldown_o = st_ff.dcd_pd;
   assign detect_voltage_source_o = st_ff.vsrc;
   assign detect_current_sink_o = st_ff.sink;
   assign adc_read_path_o = st_ff.adc;
endmodule

// [hw/tpm_tick_div.sv]
// Purpose: Divide the core clock into a one-cycle enable pulse.
// Assumes: DIV of at least one.
// Notes: Counter restarts whenever the enable drops.
`timescale 1ns/10ps
module tpm_tick_div import tpm_pkg::*; #(
   parameter int DIV = LS_TICK_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   output logic tick_o
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } tpm_div_st_t;

   localparam logic [15:0] LAST = 16'(DIV - 1);

   tpm_div_st_t st_ff;
   tpm_div_st_t nxt_st;

   // Count up to DIV-1 and pulse on the wrap.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (!run_i) begin
         nxt_st.cnt = 16'h0000;
      end else if (st_ff.cnt == LAST) begin
         nxt_st.cnt = 16'h0000;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.cnt = st_ff.cnt + 16'h0001;
      end
   end

   // Register the divider state.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick_o = st_ff.tick;
endmodule

// [verif/tb.sv]
// Purpose: Self-checking bench for the port data mux control.
// Assumes: Bit pacing shortened to four cycles.
// Notes: Inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
module tb;
   import tpm_pkg::*;
   localparam int TK = 4;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic orient_flip_i, xbar_load_i, xbar_rx_out_i, xbar_tx_out_i, serial_hiz_i, chain_rx_i;
   logic ep_tx_mode_i, contact_detect_i, charger_detect_i, sbu_swap_o, select_conflict_o;
   logic xbar_custom_o, chain_rx_o, chain_rx_oe_o, chain_tx_o, chain_tx_oe_o, tx_seen;
   logic lowspeed_bit_tick_o, chain_tx_i;
   tpm_src_t top_src_i, bottom_src_i, sbu_src_i, top_pair_src_o, bottom_pair_src_o, sbu_src_o;
   logic [1:0] xbar_chan_i, lowspeed_pullup_o, contact_detect_current_o, contact_detect_pulldown_o;
   logic [PORT_PINS-1:0] port_pin_i, port_pin_o, port_pin_oe_o, cmp_en_i, analog_pin_i, dev_lvl;
   logic [PORT_PINS-1:0] port_event_o, pull_up_i, pull_dn_i, pull_up_o, pull_dn_o, clamp_en_o;
   logic [CHG_SWITCHES-1:0] charger_sw_i;
   logic [DATA_PINS-1:0] detect_voltage_source_o, detect_current_sink_o, adc_read_path_o;
   int bad_count = 0;
   int n_compared = 0;
   tpm_port_mux #(.TICK_CYC(TK)) i_tpm_port_mux (.*);
   tpm_far_side i_tpm_far_side (.drv_i(port_pin_o), .oe_i(port_pin_oe_o), .dev_lvl_i(dev_lvl),
      .tx_i(chain_tx_o), .tx_oe_i(chain_tx_oe_o), .pin_o(port_pin_i), .tx_seen_o(tx_seen));
   // Free-running 100 MHz clock.
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // Expected {conflict, sideband, physical bottom, physical top}; top wins over bottom.
   function automatic logic [9:0] route(logic [2:0] t, logic [2:0] b, logic [2:0] s, logic f);
      logic [2:0] pt, pb, ps;
      logic c;
      pt = (t > 3'h4) ? 3'h0 : t;
      pb = (b > 3'h4) ? 3'h0 : b;
      ps = s;
      c = 1'b0;
      if (pb == pt && pt != 3'h0 && pt != 3'h4) begin
         pb = 3'h0;
         c = 1'b1;
      end
      if (ps inside {3'h1, 3'h2} || ps > 3'h4) begin
         ps = 3'h0;
         c = 1'b1;
      end
      if (ps == 3'h3 && (pt == 3'h3 || pb == 3'h3)) begin
         ps = 3'h0;
         c = 1'b1;
      end
      return f ? {c, ps, pt, pb} : {c, ps, pb, pt};
   endfunction
   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic conclude();
      if (bad_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // A hang counts as a failure.
   initial begin
      #200_000;
      bad_count++;
      conclude();
   end
   initial begin
      logic [2:0] t, b, s;
      logic [9:0] r;
      logic [1:0] o;
      logic f, ep;
      int n;
      {orient_flip_i, xbar_load_i, xbar_rx_out_i, xbar_tx_out_i, serial_hiz_i} = '0;
      {chain_rx_i, ep_tx_mode_i, contact_detect_i, charger_detect_i, xbar_chan_i} = '0;
      chain_tx_i = 1'b0;
      top_src_i = SRC_NONE;
      bottom_src_i = SRC_NONE;
      sbu_src_i = SRC_NONE;
      {cmp_en_i, analog_pin_i, pull_up_i, pull_dn_i, dev_lvl, charger_sw_i} = '0;
      void'($urandom(89071));
      step(20);
      chk({clamp_en_o, port_pin_oe_o}, 12'h000, "reset state");
      rst_i = 1'b0;
      // Power-up bypass copies the receive pin, and the driver can be released.
      for (int i = 0; i < 4; i++) begin
         chain_rx_i = 1'($urandom_range(0, 1));
         step(8);
         chk({chain_tx_oe_o, tx_seen}, {1'b1, chain_rx_i}, "bypass");
      end
      serial_hiz_i = 1'b1;
      step(3);
      chk(chain_tx_oe_o, 12'h000, "bypass release");
      serial_hiz_i = 1'b0;
      // Each pin: enabled gives one event, disabled and analog give none.
      for (int k = 0; k < PORT_PINS; k++) begin
         for (int m = 0; m < 3; m++) begin
            cmp_en_i = (m == 1) ? ~(6'h01 << k) : 6'h3F;
            analog_pin_i = (m == 2) ? (6'h01 << k) : 6'h00;
            dev_lvl[k] = ~dev_lvl[k];
            n = 0;
            repeat (10) begin
               step(1);
               n += (port_event_o[k] === 1'b1);
            end
            chk(12'(n), 12'(m == 0), "edge event");
         end
      end
      analog_pin_i = 6'h00;
      cmp_en_i = 6'h3F;
      // Random selections with forced duplicates; all terminations checked together.
      for (int i = 0; i < 80; i++) begin
         t = 3'($urandom_range(0, 4));
         b = ($urandom_range(0, 3) == 0) ? t : 3'($urandom_range(0, 7));
         s = 3'($urandom_range(0, 7));
         f = 1'($urandom_range(0, 1));
         top_src_i = tpm_src_t'(t);
         bottom_src_i = tpm_src_t'(b);
         sbu_src_i = tpm_src_t'(s);
         orient_flip_i = f;
         pull_up_i = 6'($urandom);
         pull_dn_i = 6'($urandom);
         {ep_tx_mode_i, contact_detect_i, charger_detect_i} = 3'($urandom);
         charger_sw_i = 12'($urandom);
         step(3);
         r = route(t, b, s, f);
         ep = (r[2:0] == 3'h2 || r[5:3] == 3'h2);
         o = f ? 2'h2 : 2'h1;
         chk({select_conflict_o, sbu_src_o, bottom_pair_src_o, top_pair_src_o}, r, "route");
         chk(sbu_swap_o, f, "sideband swap");
         chk(clamp_en_o, {{2{|r[8:6]}}, {2{|r[5:3]}}, {2{|r[2:0]}}}, "clamp");
         chk({pull_dn_o, pull_up_o}, {pull_dn_i & ~pull_up_i, pull_up_i & ~pull_dn_i}, "pulls");
         chk({lowspeed_pullup_o, contact_detect_current_o, contact_detect_pulldown_o},
            {(ep && !ep_tx_mode_i) ? o : 2'h0, {2{contact_detect_i ? o : 2'h0}}}, "terms");
         chk({adc_read_path_o, detect_current_sink_o, detect_voltage_source_o},
            {charger_sw_i[11:8], charger_detect_i ? charger_sw_i[7:0] : 8'h00},
            "charger");
      end
      // Endpoint on the top pair paces bits every TK cycles.
      top_src_i = SRC_LSEP;
      bottom_src_i = SRC_NONE;
      orient_flip_i = 1'b0;
      step(4);
      n = 0;
      repeat (10 * TK) begin
         step(1);
         n += (lowspeed_bit_tick_o === 1'b1);
      end
      chk(12'(n), 12'h00A, "bit ticks");
      // Each serial channel onto its own pins, loading the crossbar for each.
      for (int c = 0; c < 3; c++) begin
         top_src_i = (c == 0) ? SRC_UART : SRC_NONE;
         bottom_src_i = (c == 1) ? SRC_UART : SRC_NONE;
         sbu_src_i = (c == 2) ? SRC_UART : SRC_NONE;
         {xbar_rx_out_i, xbar_tx_out_i, xbar_chan_i, xbar_load_i} = {2'h1, 2'(c), 1'b1};
         step(1);
         xbar_load_i = 1'b0;
         chain_rx_i = 1'($urandom_range(0, 1));
         dev_lvl[2*c+1] = 1'($urandom_range(0, 1));
         step(8);
         chk({xbar_custom_o, port_pin_oe_o, port_pin_o[2*c], tx_seen},
            {1'b1, 6'h01 << (2 * c), chain_rx_i, dev_lvl[2*c+1]}, "crossbar");
      end
      // Receive pin turned output and transmit pin input, on channel zero.
      top_src_i = SRC_UART;
      sbu_src_i = SRC_NONE;
      {xbar_rx_out_i, xbar_tx_out_i, xbar_chan_i, xbar_load_i} = 5'b10001;
      chain_tx_i = 1'($urandom_range(0, 1));
      dev_lvl[1] = 1'($urandom_range(0, 1));
      step(1);
      xbar_load_i = 1'b0;
      step(8);
      chk({chain_rx_oe_o, chain_rx_o, port_pin_o[0], chain_tx_oe_o},
         {1'b1, dev_lvl[1], chain_tx_i, 1'b0}, "crossbar reversed");
      serial_hiz_i = 1'b1;
      step(3);
      chk({port_pin_oe_o, chain_tx_oe_o, chain_rx_oe_o}, 12'h000, "serial release");
      conclude();
   end
endmodule

// [verif/tpm_far_side.sv]
// Purpose: Connector side: attached device on the port pins and the chained neighbour.
// Assumes: The bench sets the device's own pin levels.
// Notes: The mux wins wherever it drives a pin.
`timescale 1ns/10ps
module tpm_far_side import tpm_pkg::*; (
   input wire logic [PORT_PINS-1:0] drv_i,
   input wire logic [PORT_PINS-1:0] oe_i,
   input wire logic [PORT_PINS-1:0] dev_lvl_i,
   input wire logic tx_i,
   input wire logic tx_oe_i,
   output logic [PORT_PINS-1:0] pin_o,
   output logic tx_seen_o
);
   // Pins resolve bit by bit.
   assign pin_o = (drv_i & oe_i) | (dev_lvl_i & ~oe_i);
   // A released chain line inverts its shown level on each change of tx_i or tx_oe_i.
   always @(tx_i or tx_oe_i) begin
      if (tx_oe_i) begin
         tx_seen_o = tx_i;
      end else begin
         tx_seen_o = ~tx_seen_o;
      end
   end
endmodule

// [verif/tpm_port_mux_sva.sv]
// Purpose: Concurrent checks on the ports of the port data mux control.
// Assumes: One clock, synchronous active-high reset, one register stage.
// Notes: Input-to-output checks other than a_eptx, a_evt, a_gate and a_bypass skip the edge that leaves reset.
`timescale 1ns/10ps
module tpm_port_mux_sva import tpm_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic orient_flip_i,
   input tpm_src_t top_src_i,
   input tpm_src_t top_pair_src_o,
   input tpm_src_t bottom_pair_src_o,
   input tpm_src_t sbu_src_o,
   input wire logic sbu_swap_o,
   input wire logic [PORT_PINS-1:0] clamp_en_o,
   input wire logic ep_tx_mode_i,
   input wire logic [1:0] lowspeed_pullup_o,
   input wire logic contact_detect_i,
   input wire logic [1:0] contact_detect_current_o,
   input wire logic charger_detect_i,
   input wire logic [CHG_SWITCHES-1:0] charger_sw_i,
   input wire logic [DATA_PINS-1:0] detect_current_sink_o,
   input wire logic [PORT_PINS-1:0] port_pin_i,
   input wire logic [PORT_PINS-1:0] cmp_en_i,
   input wire logic [PORT_PINS-1:0] analog_pin_i,
   input wire logic [PORT_PINS-1:0] port_event_o,
   input wire logic chain_rx_i,
   input wire logic chain_tx_o,
   input wire logic xbar_custom_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // An enabled digital pin changed; its event must follow unless the setup or a port pin moves.
   sequence s_live;
      |(($past(port_pin_i) ^ port_pin_i) & cmp_en_i & ~analog_pin_i);
   endsequence
   sequence s_flag;
      ##[2:6] (|port_event_o);
   endsequence
   sequence s_upset;
      ##[1:5] ($changed(cmp_en_i) || $changed(analog_pin_i) || $changed(port_pin_i));
   endsequence
   // Eight quiet cycles give the synchroniser time to settle.
   sequence s_quiet;
      (!xbar_custom_o && $stable(chain_rx_i))[*8];
   endsequence
   property p_swap;
      !$past(rst_i) |-> sbu_swap_o == $past(orient_flip_i);
   endproperty
   a_swap: assert property (p_swap)
      else $error("sideband swap does not follow orientation");
   property p_flip;
      !$past(rst_i) && $past(top_src_i) == SRC_ROOT
         |-> (sbu_swap_o ? bottom_pair_src_o : top_pair_src_o) == SRC_ROOT;
   endproperty
   a_flip: assert property (p_flip)
      else $error("root pair not on orientation-selected side");
   property p_clamp;
      clamp_en_o == {{2{sbu_src_o != SRC_NONE}}, {2{bottom_pair_src_o != SRC_NONE}},
                     {2{top_pair_src_o != SRC_NONE}}};
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("clamp does not match closed paths");
   property p_nodup;
      top_pair_src_o inside {SRC_NONE, SRC_UART} || top_pair_src_o != bottom_pair_src_o;
   endproperty
   a_nodup: assert property (p_nodup)
      else $error("one source on both pairs");
   property p_eptx;
      $past(ep_tx_mode_i) |-> lowspeed_pullup_o == 2'h0;
   endproperty
   a_eptx: assert property (p_eptx)
      else $error("pull-up attached while endpoint transmits");
   property p_dcd;
      !$past(rst_i) |-> contact_detect_current_o ==
         ($past(contact_detect_i) ? ($past(orient_flip_i) ? 2'h2 : 2'h1) : 2'h0);
   endproperty
   a_dcd: assert property (p_dcd)
      else $error("contact detect current wrong");
   property p_sink;
      !$past(rst_i) |-> detect_current_sink_o ==
         ($past(charger_detect_i) ? $past(charger_sw_i[7:4]) : 4'h0);
   endproperty
   a_sink: assert property (p_sink)
      else $error("detect sink wrong");
   property p_evt;
      s_live |-> s_flag or s_upset;
   endproperty
   a_evt: assert property (p_evt)
      else $error("no event after enabled pin edge");
   property p_gate;
      (port_event_o & ~$past(cmp_en_i)) == 6'h00 && (port_event_o & $past(analog_pin_i)) == 6'h00;
   endproperty
   a_gate: assert property (p_gate)
      else $error("event from disabled or analog pin");
   property p_bypass;
      s_quiet |-> chain_tx_o == chain_rx_i;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypass does not copy receive pin");
endmodule
bind tpm_port_mux tpm_port_mux_sva i_tpm_port_mux_sva (.*);
